// [tlic_pkg.sv]
// package for the two-level interrupt controller
package tlic_pkg;

  // ==========================================================
  // register indices, compared with bus address bits 21:2
  localparam logic [19:0] ADDR_SYSCTL = 20'hEE012;
  localparam logic [19:0] ADDR_SENSE = 20'hEE014;
  localparam logic [19:0] ADDR_ENABLE = 20'hEE015;
  localparam logic [19:0] ADDR_FLAGS = 20'hEE016;
  localparam logic [19:0] ADDR_PRIO_A = 20'hEE018;
  localparam logic [19:0] ADDR_PRIO_B = 20'hEE019;
  // byte address of each register = index * 4 on the bus
  localparam int ADDR_W = 22;

  // ==========================================================
  // reset values
  localparam logic [7:0] SYSCTL_RST = 8'h09;
  localparam logic [7:0] ZERO_RST = 8'h00;

  // ==========================================================
  // field positions
  localparam int SYS_USER_EN_BIT = 3;
  localparam int SYS_NMI_EDGE_BIT = 2;
  localparam int PA_PIN0 = 7;
  localparam int PA_PIN1 = 6;
  localparam int PA_PIN23 = 5;
  localparam int PA_PIN45 = 4;
  localparam int PA_WDOG = 3;
  localparam int PA_T16C0 = 2;
  localparam int PA_T16C1 = 1;
  localparam int PA_T16C2 = 0;
  localparam int PB_T8A = 7;
  localparam int PB_T8B = 6;
  localparam int PB_DMAC = 5;
  localparam int PB_SCI0 = 3;
  localparam int PB_SCI1 = 2;
  localparam int PB_SCI2 = 1;
  localparam int NPIN = 6;

  // ==========================================================
  // vector numbers
  localparam logic [5:0] VEC_NMI = 6'h07;
  localparam logic [5:0] VEC_PIN0 = 6'h0C;
  localparam logic [5:0] VEC_INT0 = 6'h14;
  localparam int NINT = 44;

  // internal source group of each internal vector (20..63)
  typedef enum {
    GRP_WDOG, GRP_T16C0, GRP_T16C1, GRP_T16C2, GRP_T8A, GRP_T8B,
    GRP_DMAC, GRP_SCI0, GRP_SCI1, GRP_SCI2, GRP_NONE
  } tlic_grp_t;

  // mask bits of the cpu condition code register
  typedef struct packed {
    logic global_mask;
    logic user_mask_bit;
  } tlic_cc_mask_t;

  // request presented to the cpu core
  typedef struct packed {
    logic valid;
    logic nmi;
    logic [5:0] vector;
  } tlic_req_t;

endpackage

// [tlic_ctrl.sv]
// two-level interrupt controller with avalon-mm register slave
`timescale 1ns/100ps
module tlic_ctrl
  import tlic_pkg::*;
(
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic clk_en_i,
  input wire logic hw_standby_i,
  // avalon-mm slave
  input wire logic [tlic_pkg::ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // request sources
  input wire logic nmi_i,
  input wire logic [5:0] ext_req_n_i,
  input wire logic [tlic_pkg::NINT-1:0] int_req_i,
  // cpu core
  input wire tlic_pkg::tlic_cc_mask_t cc_mask_i,
  input wire logic ack_i,
  output tlic_pkg::tlic_req_t cpu_req_o,
  output logic user_bit_enable_o
);
  import tlic_pkg::*;

  // ==========================================================
  // reset synchroniser
  logic rst_s1_q, rst_n_q;
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  // ==========================================================
  // group of each internal vector
  function automatic tlic_grp_t grp_of(input int v);
    if (v <= 22) return GRP_WDOG;
    if (v <= 23) return GRP_NONE;
    if (v <= 27) return GRP_T16C0;
    if (v <= 31) return GRP_T16C1;
    if (v <= 35) return GRP_T16C2;
    if (v <= 39) return GRP_T8A;
    if (v <= 43) return GRP_T8B;
    if (v <= 47) return GRP_DMAC;
    if (v <= 51) return GRP_SCI0;
    if (v <= 55) return GRP_SCI1;
    if (v <= 59) return GRP_SCI2;
    return GRP_NONE;
  endfunction

  // ==========================================================
  // registers
  logic [7:0] sysctl_q, sense_q, enable_q, flags_q, prio_a_q, prio_b_q;
  logic [7:0] rd_byte;
  logic [19:0] byte_addr;
  logic bus_req, wr_hit, flags_rd;
  logic [5:0] flags_seen_q;
  logic [5:0] pin_q;
  logic nmi_q;
  logic [5:0] pin_set, pin_auto_clr, pin_sw_clr;

  assign byte_addr = avs_address_i[21:2];
  assign bus_req = (avs_read_i || avs_write_i) && avs_waitrequest_o;
  // writes commit on the edge that completes the transfer
  assign wr_hit = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
  assign flags_rd = avs_read_i && avs_waitrequest_o
                    && byte_addr == ADDR_FLAGS;

  // one wait state: answer on the edge after request is seen
  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= 32'h0000_0000;
    end else if (clk_en_i) begin
      if (bus_req) begin
        avs_waitrequest_o <= 1'b0;
        avs_readdata_o <= {24'h00_0000, avs_read_i ? rd_byte : 8'h00};
      end else begin
        avs_waitrequest_o <= 1'b1;
      end
    end
  end

  always_comb begin
    unique case (byte_addr)
      ADDR_SYSCTL: rd_byte = sysctl_q;
      ADDR_SENSE: rd_byte = sense_q;
      ADDR_ENABLE: rd_byte = enable_q;
      ADDR_FLAGS: rd_byte = {2'b00, flags_q[5:0]};
      ADDR_PRIO_A: rd_byte = prio_a_q;
      ADDR_PRIO_B: rd_byte = prio_b_q;
      default: rd_byte = 8'h00;
    endcase
  end

  // plain read/write registers; hardware standby reinitialises
  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      sysctl_q <= SYSCTL_RST;
      sense_q <= ZERO_RST;
      enable_q <= ZERO_RST;
      prio_a_q <= ZERO_RST;
      prio_b_q <= ZERO_RST;
    end else if (hw_standby_i) begin
      sysctl_q <= SYSCTL_RST;
      sense_q <= ZERO_RST;
      enable_q <= ZERO_RST;
      prio_a_q <= ZERO_RST;
      prio_b_q <= ZERO_RST;
    end else if (clk_en_i && wr_hit) begin
      unique case (byte_addr)
        ADDR_SYSCTL: sysctl_q <= avs_writedata_i[7:0];
        ADDR_SENSE: sense_q <= avs_writedata_i[7:0];
        ADDR_ENABLE: enable_q <= avs_writedata_i[7:0];
        ADDR_PRIO_A: prio_a_q <= avs_writedata_i[7:0];
        ADDR_PRIO_B: prio_b_q <= avs_writedata_i[7:0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // pin sampling and flag logic
  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pin_q <= 6'h3F;
      nmi_q <= 1'b1;
      flags_seen_q <= 6'h00;
    end else if (clk_en_i) begin
      pin_q <= ext_req_n_i;
      nmi_q <= nmi_i;
      if (flags_rd)
        flags_seen_q <= flags_q[5:0];
    end
  end

  always_comb begin
    for (int n = 0; n < NPIN; n++) begin
      // low level or falling edge
      pin_set[n] = sense_q[n] ? (pin_q[n] && !ext_req_n_i[n])
                              : !ext_req_n_i[n];
      // edge mode flag drops when its exception is taken
      pin_auto_clr[n] = sense_q[n] && ack_i && !cpu_req_o.nmi
                        && cpu_req_o.vector == VEC_PIN0 + 6'(n);
      // zero written after read as one; level needs pin high
      pin_sw_clr[n] = wr_hit && byte_addr == ADDR_FLAGS
                      && !avs_writedata_i[n] && flags_seen_q[n]
                      && (sense_q[n] || ext_req_n_i[n]);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      flags_q <= ZERO_RST;
    end else if (hw_standby_i) begin
      flags_q <= ZERO_RST;
    end else if (clk_en_i) begin
      // set wins over clear; writing 1 never sets
      flags_q[5:0] <= pin_set | (flags_q[5:0]
                      & ~(pin_sw_clr | pin_auto_clr));
      flags_q[7:6] <= 2'b00;
    end
  end

  // ==========================================================
  // nonmaskable request latch
  logic nmi_edge, nmi_pend_q;
  assign nmi_edge = sysctl_q[SYS_NMI_EDGE_BIT] ? (!nmi_q && nmi_i)
                                            : (nmi_q && !nmi_i);
  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q)
      nmi_pend_q <= 1'b0;
    else if (clk_en_i)
      nmi_pend_q <= nmi_edge
                    || (nmi_pend_q && !(ack_i && cpu_req_o.nmi));
  end

  // ==========================================================
  // priority level per source and arbitration
  logic [5:0] pin_lvl;
  logic [NINT-1:0] int_lvl;
  logic allow_lo, allow_hi;
  logic [5:0] best_vec;
  logic best_ok, best_hi;
  assign pin_lvl = {prio_a_q[PA_PIN45], prio_a_q[PA_PIN45],
                    prio_a_q[PA_PIN23], prio_a_q[PA_PIN23],
                    prio_a_q[PA_PIN1], prio_a_q[PA_PIN0]};

  always_comb begin
    for (int i = 0; i < NINT; i++) begin
      unique case (grp_of(i + 20))
        GRP_WDOG: int_lvl[i] = prio_a_q[PA_WDOG];
        GRP_T16C0: int_lvl[i] = prio_a_q[PA_T16C0];
        GRP_T16C1: int_lvl[i] = prio_a_q[PA_T16C1];
        GRP_T16C2: int_lvl[i] = prio_a_q[PA_T16C2];
        GRP_T8A: int_lvl[i] = prio_b_q[PB_T8A];
        GRP_T8B: int_lvl[i] = prio_b_q[PB_T8B];
        GRP_DMAC: int_lvl[i] = prio_b_q[PB_DMAC];
        GRP_SCI0: int_lvl[i] = prio_b_q[PB_SCI0];
        GRP_SCI1: int_lvl[i] = prio_b_q[PB_SCI1];
        GRP_SCI2: int_lvl[i] = prio_b_q[PB_SCI2];
        default: int_lvl[i] = 1'b0;
      endcase
    end
  end

  // masking: user bit joins only when user_bit_enable is 0
  always_comb begin
    allow_lo = !cc_mask_i.global_mask;
    allow_hi = !cc_mask_i.global_mask
               || (!sysctl_q[SYS_USER_EN_BIT]
                   && !cc_mask_i.user_mask_bit);
  end

  // scan from highest vector down so lowest wins per level
  always_comb begin
    best_ok = 1'b0;
    best_hi = 1'b0;
    best_vec = 6'h00;
    for (int i = NINT - 1; i >= 0; i--) begin
      if (int_req_i[i] && (int_lvl[i] ? allow_hi : allow_lo)
          && (int_lvl[i] || !best_hi)) begin
        best_ok = 1'b1;
        best_hi = int_lvl[i];
        best_vec = VEC_INT0 + 6'(i);
      end
    end
    for (int n = NPIN - 1; n >= 0; n--) begin
      if (flags_q[n] && enable_q[n]
          && (pin_lvl[n] ? allow_hi : allow_lo)
          && (pin_lvl[n] || !best_hi)) begin
        best_ok = 1'b1;
        best_hi = pin_lvl[n];
        best_vec = VEC_PIN0 + 6'(n);
      end
    end
  end

  // ==========================================================
  // request to the core
  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      cpu_req_o <= '0;
      user_bit_enable_o <= 1'b1;
    end else if (clk_en_i) begin
      user_bit_enable_o <= sysctl_q[SYS_USER_EN_BIT];
      if (nmi_pend_q && !(ack_i && cpu_req_o.nmi))
        cpu_req_o <= '{valid: 1'b1, nmi: 1'b1, vector: VEC_NMI};
      else if (best_ok && !ack_i)
        cpu_req_o <= '{valid: 1'b1, nmi: 1'b0, vector: best_vec};
      else
        cpu_req_o <= '0;
    end
  end

  // ==========================================================
  // checks
  property p_nmi_wins;
    @(posedge clk_i) disable iff (!rst_n_q)
    (clk_en_i && nmi_pend_q && !ack_i) |=> cpu_req_o.nmi
      && cpu_req_o.vector == VEC_NMI;
  endproperty
  a_nmi_wins: assert property (p_nmi_wins)
    else $error("nonmaskable request not presented");

  property p_mask_all;
    @(posedge clk_i) disable iff (!rst_n_q)
    (clk_en_i && cc_mask_i.global_mask && !sysctl_q[SYS_USER_EN_BIT]
     && cc_mask_i.user_mask_bit && !nmi_pend_q) |=> !cpu_req_o.valid;
  endproperty
  a_mask_all: assert property (p_mask_all)
    else $error("request passed full mask");

  property p_user_flag;
    @(posedge clk_i) disable iff (!rst_n_q)
    (clk_en_i && cc_mask_i.global_mask && sysctl_q[SYS_USER_EN_BIT]
     && !nmi_pend_q) |=> !cpu_req_o.valid;
  endproperty
  a_user_flag: assert property (p_user_flag)
    else $error("request passed global mask with user flag");

  property p_lo_masked;
    @(posedge clk_i) disable iff (!rst_n_q)
    ($past(clk_en_i) && $past(cc_mask_i.global_mask) && cpu_req_o.valid
     && !cpu_req_o.nmi) |-> $past(best_hi);
  endproperty
  a_lo_masked: assert property (p_lo_masked)
    else $error("low level request passed global mask");

  property p_flag_one;
    @(posedge clk_i) disable iff (!rst_n_q)
    (clk_en_i && !hw_standby_i && !pin_set[0] && !flags_q[0])
      |=> !flags_q[0];
  endproperty
  a_flag_one: assert property (p_flag_one)
    else $error("flag set without pin event");

  property p_level_set;
    @(posedge clk_i) disable iff (!rst_n_q)
    (clk_en_i && !hw_standby_i && !sense_q[1] && !ext_req_n_i[1])
      |=> flags_q[1];
  endproperty
  a_level_set: assert property (p_level_set)
    else $error("low level did not set flag");

  property p_edge_only;
    @(posedge clk_i) disable iff (!rst_n_q)
    (clk_en_i && !hw_standby_i && sense_q[2] && !flags_q[2]
     && !pin_q[2]) |=> !flags_q[2];
  endproperty
  a_edge_only: assert property (p_edge_only)
    else $error("edge mode flag set by steady low");

  property p_standby;
    @(posedge clk_i) disable iff (!rst_n_q)
    hw_standby_i |=> sysctl_q == SYSCTL_RST && prio_a_q == ZERO_RST
      && prio_b_q == ZERO_RST;
  endproperty
  a_standby: assert property (p_standby)
    else $error("standby did not reinitialise registers");

  property p_nmi_edge;
    @(posedge clk_i) disable iff (!rst_n_q)
    (clk_en_i && !sysctl_q[SYS_NMI_EDGE_BIT] && nmi_q && !nmi_i)
      |=> nmi_pend_q;
  endproperty
  a_nmi_edge: assert property (p_nmi_edge)
    else $error("falling nonmaskable edge missed");

  property p_bus_answer;
    @(posedge clk_i) disable iff (!rst_n_q)
    (clk_en_i && bus_req) |=> !avs_waitrequest_o ##1 avs_waitrequest_o;
  endproperty
  a_bus_answer: assert property (p_bus_answer)
    else $error("bus answer not one cycle");

  c_nmi: cover property (@(posedge clk_i) cpu_req_o.nmi);
  c_hi: cover property (@(posedge clk_i) cpu_req_o.valid
    && cc_mask_i.global_mask && !cpu_req_o.nmi);
  c_clr: cover property (@(posedge clk_i) |pin_sw_clr);
  c_auto: cover property (@(posedge clk_i) |pin_auto_clr);
  c_flag_mask: cover property (@(posedge clk_i) cc_mask_i.global_mask
    && sysctl_q[SYS_USER_EN_BIT] && |int_req_i);

endmodule

// [tlic_core_model.sv]
// cpu core model that takes requests presented by the controller
`timescale 1ns/100ps
module tlic_core_model
  import tlic_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // bench control
  input wire logic arm_i,
  input wire logic [3:0] delay_i,
  // controller side
  input wire tlic_pkg::tlic_req_t req_i,
  output logic ack_o,
  output logic [5:0] last_vec_o
);
  import tlic_pkg::*;
  logic [3:0] wait_q;
  logic done_q;

  // ==========================================================
  // one acknowledge per arming, after delay_i cycles of valid
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ack_o <= 1'b0;
      wait_q <= 4'h0;
      done_q <= 1'b0;
      last_vec_o <= 6'h00;
    end else begin
      ack_o <= 1'b0;
      if (!arm_i) begin
        done_q <= 1'b0;
        wait_q <= 4'h0;
      end else if (req_i.valid && !done_q && !ack_o) begin
        if (wait_q >= delay_i) begin
          ack_o <= 1'b1;
          done_q <= 1'b1;
          last_vec_o <= req_i.vector;
        end else begin
          wait_q <= wait_q + 4'h1;
        end
      end
    end
  end
endmodule

// [tb_top.sv]
// self-checking bench for the two-level interrupt controller
`timescale 1ns/100ps
module tb_top;
  import tlic_pkg::*;
  // ==========================================================
  // signals
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic hw_standby_i = 1'b0;
  logic [ADDR_W-1:0] avs_address_i = '0;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = '0;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic nmi_i = 1'b1;
  logic [5:0] ext_req_n_i = 6'h3F;
  logic [NINT-1:0] int_req_i = '0;
  tlic_cc_mask_t cc_mask_i = '0;
  logic ack_i;
  tlic_req_t cpu_req_o;
  logic user_bit_enable_o;
  logic arm = 1'b0;
  logic [3:0] delay = 4'h0;
  logic [5:0] last_vec;
  int n_mismatch = 0;
  int num_checks = 0;

  always #10 clk_i = ~clk_i;

  tlic_ctrl i_dut (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .clk_en_i(1'b1),
    .hw_standby_i(hw_standby_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'hF),
    .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .nmi_i(nmi_i),
    .ext_req_n_i(ext_req_n_i), .int_req_i(int_req_i),
    .cc_mask_i(cc_mask_i), .ack_i(ack_i), .cpu_req_o(cpu_req_o),
    .user_bit_enable_o(user_bit_enable_o)
  );

  tlic_core_model i_core (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .arm_i(arm), .delay_i(delay),
    .req_i(cpu_req_o), .ack_o(ack_i), .last_vec_o(last_vec)
  );

  // ==========================================================
  // shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [19:0] a,
                     input logic [7:0] wd, output logic [7:0] rd);
    logic done;
    done = 1'b0;
    rd = 8'h00;
    avs_address_i <= {a, 2'b00};
    avs_read_i <= !wr;
    avs_write_i <= wr;
    avs_writedata_i <= {24'h0, wd};
    // hold until the rising edge that sees waitrequest low
    while (!done) begin
      @(posedge clk_i);
      done = (avs_waitrequest_o === 1'b0);
      rd = avs_readdata_o[7:0];
    end
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wreg(input logic [19:0] a, input logic [7:0] d);
    logic [7:0] r;
    bus(1'b1, a, d, r);
  endtask

  task automatic rchk(input logic [19:0] a, input logic [7:0] e);
    logic [7:0] r;
    bus(1'b0, a, 8'h00, r);
    chk({24'h0, r}, {24'h0, e});
  endtask

  // request seen by the core after the two-cycle answer
  task automatic req_chk(input logic [7:0] e);
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    chk({24'h0, cpu_req_o}, {24'h0, e});
    @(posedge clk_i);
  endtask

  function automatic logic [7:0] rq(input logic [5:0] v);
    return {2'b10, v};
  endfunction

  // ==========================================================
  // scenarios
  task automatic t_reset();
    rchk(ADDR_SYSCTL, SYSCTL_RST);
    rchk(ADDR_SENSE, ZERO_RST);
    rchk(ADDR_ENABLE, ZERO_RST);
    rchk(ADDR_FLAGS, ZERO_RST);
    rchk(ADDR_PRIO_A, ZERO_RST);
    rchk(ADDR_PRIO_B, ZERO_RST);
    rchk(20'hEE013, 8'h00);
    chk({31'h0, user_bit_enable_o}, 32'h1);
    $display("test reset done");
  endtask

  task automatic t_regs();
    logic [19:0] rw [4];
    rw = '{ADDR_SENSE, ADDR_ENABLE, ADDR_PRIO_A, ADDR_PRIO_B};
    foreach (rw[i]) wreg(rw[i], 8'hFF);
    foreach (rw[i]) rchk(rw[i], 8'hFF);
    wreg(ADDR_FLAGS, 8'hFF);
    rchk(ADDR_FLAGS, 8'h00);
    wreg(20'hEE013, 8'hFF);
    rchk(20'hEE013, 8'h00);
    wreg(ADDR_SYSCTL, 8'h01);
    // output copy follows one edge after the write lands
    @(posedge clk_i);
    chk({31'h0, user_bit_enable_o}, 32'h0);
    hw_standby_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    hw_standby_i <= 1'b0;
    @(posedge clk_i);
    rchk(ADDR_SYSCTL, SYSCTL_RST);
    foreach (rw[i]) rchk(rw[i], ZERO_RST);
    $display("test registers done");
  endtask

  task automatic t_pins();
    logic [7:0] pa [5];
    logic [5:0] ev [5];
    pa = '{8'h00, 8'h40, 8'hC0, 8'h20, 8'h10};
    ev = '{6'h00, 6'h01, 6'h00, 6'h02, 6'h04};
    wreg(ADDR_ENABLE, 8'h3F);
    ext_req_n_i <= 6'h00;
    foreach (pa[i]) begin
      wreg(ADDR_PRIO_A, pa[i]);
      req_chk(rq(VEC_PIN0 + ev[i]));
    end
    wreg(ADDR_PRIO_A, 8'h00);
    wreg(ADDR_ENABLE, 8'h3E);
    req_chk(rq(VEC_PIN0 + 6'h01));
    ext_req_n_i <= 6'h3F;
    rchk(ADDR_FLAGS, 8'h3F);
    wreg(ADDR_FLAGS, 8'h00);
    rchk(ADDR_FLAGS, 8'h00);
    wreg(ADDR_ENABLE, 8'h00);
    $display("test pin priority done");
  endtask

  task automatic t_edge();
    wreg(ADDR_SENSE, 8'h04);
    wreg(ADDR_ENABLE, 8'h04);
    ext_req_n_i <= 6'h3B;
    req_chk(rq(VEC_PIN0 + 6'h02));
    delay <= 4'h3;
    arm <= 1'b1;
    repeat (10) @(posedge clk_i);
    arm <= 1'b0;
    chk({26'h0, last_vec}, {26'h0, VEC_PIN0 + 6'h02});
    rchk(ADDR_FLAGS, 8'h00);
    req_chk(8'h00);
    ext_req_n_i <= 6'h3F;
    wreg(ADDR_ENABLE, 8'h00);
    wreg(ADDR_SENSE, 8'h00);
    $display("test edge sensing done");
  endtask

  task automatic t_mask();
    logic [7:0] sy [7];
    logic [7:0] pa [7];
    logic [1:0] cc [7];
    logic [5:0] ev [7];
    sy = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h09, 8'h09};
    pa = '{8'h04, 8'h04, 8'h04, 8'h08, 8'h00, 8'h04, 8'h04};
    cc = '{2'b00, 2'b10, 2'b11, 2'b10, 2'b10, 2'b01, 2'b10};
    ev = '{6'h18, 6'h18, 6'h00, 6'h14, 6'h00, 6'h18, 6'h00};
    int_req_i <= 44'h011;
    foreach (sy[i]) begin
      wreg(ADDR_SYSCTL, sy[i]);
      wreg(ADDR_PRIO_A, pa[i]);
      cc_mask_i <= cc[i];
      req_chk(ev[i] == 6'h00 ? 8'h00 : rq(ev[i]));
    end
    int_req_i <= 44'h1111;
    cc_mask_i <= 2'b00;
    for (int k = 0; k < 3; k++) begin
      wreg(ADDR_PRIO_A, 8'h04 >> k);
      req_chk(rq(VEC_INT0 + 6'(4 * (k + 1))));
    end
    int_req_i <= 44'h010;
    cc_mask_i <= 2'b00;
    wreg(ADDR_SYSCTL, SYSCTL_RST);
    $display("test masking done");
  endtask

  task automatic t_nmi();
    nmi_i <= 1'b0;
    req_chk({2'b11, VEC_NMI});
    delay <= 4'h0;
    arm <= 1'b1;
    repeat (4) @(posedge clk_i);
    arm <= 1'b0;
    chk({26'h0, last_vec}, {26'h0, VEC_NMI});
    nmi_i <= 1'b1;
    req_chk(rq(VEC_INT0 + 6'h04));
    wreg(ADDR_SYSCTL, 8'h0D);
    nmi_i <= 1'b0;
    req_chk(rq(VEC_INT0 + 6'h04));
    cc_mask_i <= 2'b11;
    nmi_i <= 1'b1;
    req_chk({2'b11, VEC_NMI});
    $display("test nonmaskable done");
  endtask

  // ==========================================================
  // sequence, watchdog and verdict
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge clk_i);
    arst_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    t_reset();
    t_regs();
    t_pins();
    t_edge();
    t_mask();
    t_nmi();
    final_report();
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    n_mismatch++;
    final_report();
  end
endmodule
